// [ocm_pkg.sv]
package ocm_pkg;
  // ---------------------------------------------------------------
  // object dictionary indices
  // ---------------------------------------------------------------
  localparam logic [15:0] OCM_IDX_IN4 = 16'h2080; // 4-byte input object
  localparam logic [15:0] OCM_IDX_OUT4 = 16'h21F0; // 4-byte output object
  localparam logic [15:0] OCM_IDX_RX_PAR = 16'h1400; // rx pdo params
  localparam logic [15:0] OCM_IDX_RX_MAP = 16'h1600; // rx pdo mapping
  localparam logic [15:0] OCM_IDX_TX_PAR = 16'h1800; // tx pdo params
  localparam logic [15:0] OCM_IDX_TX_MAP = 16'h1A00; // tx pdo mapping
  // ---------------------------------------------------------------
  // register address limits
  // ---------------------------------------------------------------
  localparam logic [15:0] OCM_ADDR_OFF = 16'hFFFF; // disables an object
  localparam logic [15:0] OCM_ADDR_HIGH = 16'h0100; // pairing limit
  localparam logic [15:0] OCM_FORBID0 = 16'h0001;
  localparam logic [15:0] OCM_FORBID1 = 16'h0002;
  localparam logic [15:0] OCM_FORBID2 = 16'h0004;
  localparam logic [15:0] OCM_FORBID3 = 16'h0005;
  localparam logic [15:0] OCM_FORBID4 = 16'h0014;
  // ---------------------------------------------------------------
  // emergency and layout
  // ---------------------------------------------------------------
  localparam logic [15:0] OCM_EMCY_CODE = 16'h6301; // content busy code
  localparam logic [7:0] OCM_NUM_ENTRIES = 8'h02; // subindex 0 value
  localparam int OCM_RX_COUNT = 15;
  localparam int OCM_TX_COUNT = 16;
  localparam logic [10:0] OCM_COB_RX1 = 11'h200;
  localparam logic [10:0] OCM_COB_RX2 = 11'h300;
  localparam logic [10:0] OCM_COB_TX1 = 11'h180;
  localparam logic [10:0] OCM_COB_TX2 = 11'h280;
  localparam logic [31:0] OCM_COB_NONE = 32'h8000_0000; // not assigned
  // ---------------------------------------------------------------
  // answer codes and sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    OCM_ANS_OK = 2'h0,
    OCM_ANS_ERR = 2'h1,
    OCM_ANS_EMCY = 2'h2
  } ocm_ans_t;
  typedef enum logic [1:0]
  {
    OCM_ST_IDLE = 2'b00,
    OCM_ST_CHECK = 2'b01,
    OCM_ST_STOP = 2'b11,
    OCM_ST_RESET = 2'b10
  } ocm_state_t;
endpackage : ocm_pkg

// [ocm_fifo.sv]
// small fifo with valid and ready on both sides
module ocm_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg; // write pointer
  logic [AW-1:0] rd_reg; // read pointer
  logic [AW:0] cnt_reg; // fill level
  logic push;
  logic pop;
  assign in_ready = (cnt_reg != AW'(0) + (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // ---------------------------------------------------------------
  // storage and pointers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      if (pop)
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem_reg[wr_reg] <= in_data;
  end
  // ---------------------------------------------------------------
  // registered head of queue
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (!out_valid || out_ready)
    begin
      out_valid <= (cnt_reg != '0) && !(pop && cnt_reg == (AW+1)'(1));
      out_data <= pop ? mem_reg[(rd_reg == AW'(DEPTH - 1)) ? '0 :
                                rd_reg + 1'b1] : mem_reg[rd_reg];
    end
  end
endmodule : ocm_fifo

// [ocm_mapper.sv]
// What this block does
// - data subindex carries addressed drive register
// - subindex 0 count, 1 data, 2 address
// - address writable only when pre-operational
// - content change needs pre-op and stopped
// - refuse operational while selecting, emergency 6301
// - other request while selecting gets emergency 6301
// - reset node while running with changed mapping: stop first
// - 2080 pairs at or above 0100 must be consecutive
// - 21F0 accepts any two registers
// - one register linked to one object only
// - registers 1,2,4,5,14 rejected with error
// - fifteen receive, sixteen transmit PDOs
// - receive PDO 1 and 2 defaults
// - transmit PDO 1 and 2 defaults
// - receive params 1400+n-1, mapping 1600+n-1
// - transmit params 1800+n-1, mapping 1A00+n-1
// - receive PDOs 36-41 map manufacturer objects
// - transmit PDOs 36-41 map manufacturer objects
// - four-byte address: upper word first register
// - FFFF disables object, data reads zero
module ocm_mapper
  import ocm_pkg::*;
#(
  parameter int NOBJ = 4, // number of selectable objects
  parameter int FIFO_DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic node_preop, // node is pre-operational
  input wire logic drive_run, // run command active
  input wire logic [6:0] node_id,
  // address write request
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [$clog2(NOBJ)-1:0] wr_obj,
  input wire logic [31:0] wr_addr,
  // other requests from the master
  input wire logic go_oper_req, // switch to operational
  input wire logic other_req, // any other request or run
  input wire logic reset_node_req,
  // answers
  output logic ans_valid,
  input wire logic ans_ready,
  output logic [1:0] ans_code,
  output logic [15:0] emcy_code,
  output logic go_oper_ok, // transition accepted pulse
  output logic stop_drive, // drive stop command level
  output logic do_reset, // reset node pulse
  // object read port
  input wire logic [$clog2(NOBJ)-1:0] rd_obj,
  input wire logic [1:0] rd_sub,
  output logic [31:0] rd_data,
  // drive register fetch for the data subindex
  output logic [15:0] drv_addr,
  input wire logic [15:0] drv_data,
  // pdo table lookup
  input wire logic pdo_tx, // 1 selects transmit table
  input wire logic [5:0] pdo_num,
  output logic pdo_exists,
  output logic [15:0] pdo_par_idx,
  output logic [15:0] pdo_map_idx,
  output logic [31:0] pdo_cob_id,
  output logic [31:0] pdo_map1,
  output logic [31:0] pdo_map2
);
  import ocm_pkg::*;
  localparam int OW = $clog2(NOBJ);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  ocm_state_t state_reg; // selection sequencer
  logic [31:0] link_reg [NOBJ]; // current links, ffff means off
  logic [OW-1:0] obj_reg; // object under check
  logic [31:0] addr_reg; // address under check
  logic [31:0] data_reg [NOBJ]; // captured data subindex values
  logic [OW-1:0] scan_reg; // object being refreshed
  logic scan_lo_reg; // refresh half
  logic fifo_ready;
  logic ans_push;
  logic [1:0] ans_push_code;
  logic [17:0] ans_word;
  logic busy;
  logic mapped_dirty_reg; // mapping differs from default
  logic emcy_pend_reg; // emergency owed to the master, not yet queued
  logic bad_forbid;
  logic bad_pair;
  logic bad_dup;
  logic [15:0] hi_w;
  logic [15:0] lo_w;
  assign busy = (state_reg != OCM_ST_IDLE);
  assign wr_ready = !busy && fifo_ready;
  assign hi_w = addr_reg[31:16];
  assign lo_w = addr_reg[15:0];
  // forbidden register check on either half
  function automatic logic forbidden(input logic [15:0] a);
    forbidden = (a == OCM_FORBID0) || (a == OCM_FORBID1) ||
                (a == OCM_FORBID2) || (a == OCM_FORBID3) ||
                (a == OCM_FORBID4);
  endfunction : forbidden
  assign bad_forbid = forbidden(hi_w) || forbidden(lo_w);
  // pairing limit only for the even (input) objects, odd ones are free
  always_comb
  begin
    bad_pair = 1'b0;
    if (obj_reg[0] == 1'b0 && hi_w != OCM_ADDR_OFF &&
        lo_w != OCM_ADDR_OFF &&
        (hi_w >= OCM_ADDR_HIGH || lo_w >= OCM_ADDR_HIGH))
      bad_pair = (lo_w != hi_w + 16'h0001);
  end
  // uniqueness across all other objects
  always_comb
  begin
    bad_dup = 1'b0;
    for (int i = 0; i < NOBJ; i++)
    begin
      if (OW'(i) != obj_reg)
      begin
        for (int h = 0; h < 2; h++)
        begin
          if (addr_reg[16*h +: 16] != OCM_ADDR_OFF &&
              (addr_reg[16*h +: 16] == link_reg[i][31:16] ||
               addr_reg[16*h +: 16] == link_reg[i][15:0]))
            bad_dup = 1'b1;
        end
      end
    end
    if (hi_w != OCM_ADDR_OFF && hi_w == lo_w)
      bad_dup = 1'b1;
  end
  // ---------------------------------------------------------------
  // sequencer: check writes, guard mode changes, reset node
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= OCM_ST_IDLE;
      obj_reg <= '0;
      addr_reg <= '0;
    end
    else
    begin
      case (state_reg)
        OCM_ST_IDLE:
        begin
          if (reset_node_req && drive_run && mapped_dirty_reg)
            state_reg <= OCM_ST_STOP;
          else if (reset_node_req)
            state_reg <= OCM_ST_RESET;
          else if (wr_valid && wr_ready)
          begin
            obj_reg <= wr_obj;
            addr_reg <= wr_addr;
            state_reg <= OCM_ST_CHECK;
          end
        end
        OCM_ST_CHECK:
          state_reg <= OCM_ST_IDLE;
        OCM_ST_STOP:
          if (!drive_run)
            state_reg <= OCM_ST_RESET;
        OCM_ST_RESET:
          state_reg <= OCM_ST_IDLE;
        default:
          state_reg <= OCM_ST_IDLE;
      endcase
    end
  end
  assign stop_drive = (state_reg == OCM_ST_STOP);
  assign do_reset = (state_reg == OCM_ST_RESET);
  // ---------------------------------------------------------------
  // link table update
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < NOBJ; i++)
        link_reg[i] <= {OCM_ADDR_OFF, OCM_ADDR_OFF};
      mapped_dirty_reg <= 1'b0;
    end
    else if (state_reg == OCM_ST_CHECK && node_preop && !drive_run &&
             !bad_forbid && !bad_pair && !bad_dup)
    begin
      link_reg[obj_reg] <= addr_reg;
      mapped_dirty_reg <= 1'b1;
    end
    else if (state_reg == OCM_ST_RESET)
    begin
      for (int i = 0; i < NOBJ; i++)
        link_reg[i] <= {OCM_ADDR_OFF, OCM_ADDR_OFF};
      mapped_dirty_reg <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // answers through the fifo
  // ---------------------------------------------------------------
  always_comb
  begin
    ans_push = 1'b0;
    ans_push_code = OCM_ANS_OK;
    if (state_reg == OCM_ST_CHECK)
    begin
      ans_push = 1'b1;
      if (!node_preop || drive_run || bad_forbid || bad_pair || bad_dup)
        ans_push_code = OCM_ANS_ERR;
    end
    else if (emcy_pend_reg)
    begin
      ans_push = 1'b1;
      ans_push_code = OCM_ANS_EMCY;
    end
  end
  // a refused request during the check cycle must not be lost behind the
  // write answer, so it waits here until the queue slot is free
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      emcy_pend_reg <= 1'b0;
    else if (busy && (go_oper_req || other_req))
      emcy_pend_reg <= 1'b1;
    else if (state_reg != OCM_ST_CHECK && fifo_ready)
      emcy_pend_reg <= 1'b0;
  end
  assign go_oper_ok = go_oper_req && !busy;
  ocm_fifo #(
    .WIDTH(18),
    .DEPTH(FIFO_DEPTH)
  ) u_ans_fifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .in_valid(ans_push),
    .in_ready(fifo_ready),
    .in_data({ans_push_code,
              (ans_push_code == OCM_ANS_EMCY) ? OCM_EMCY_CODE : 16'h0000}),
    .out_valid(ans_valid),
    .out_ready(ans_ready),
    .out_data(ans_word)
  );
  assign ans_code = ans_word[17:16];
  assign emcy_code = ans_word[15:0];
  // ---------------------------------------------------------------
  // data refresh: fetch each linked register in turn
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scan_reg <= '0;
      scan_lo_reg <= 1'b0;
      for (int i = 0; i < NOBJ; i++)
        data_reg[i] <= '0;
    end
    else
    begin
      scan_lo_reg <= !scan_lo_reg;
      if (scan_lo_reg)
        scan_reg <= (scan_reg == OW'(NOBJ - 1)) ? '0 : scan_reg + 1'b1;
      // upper half from first register, lower from second
      if (drv_addr == OCM_ADDR_OFF)
      begin
        if (scan_lo_reg)
          data_reg[scan_reg][15:0] <= '0;
        else
          data_reg[scan_reg][31:16] <= '0;
      end
      else if (scan_lo_reg)
        data_reg[scan_reg][15:0] <= drv_data;
      else
        data_reg[scan_reg][31:16] <= drv_data;
    end
  end
  assign drv_addr = scan_lo_reg ? link_reg[scan_reg][15:0] :
                    link_reg[scan_reg][31:16];
  // ---------------------------------------------------------------
  // object read port
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rd_data <= '0;
    else
      case (rd_sub)
        2'd0: rd_data <= {24'h00_0000, OCM_NUM_ENTRIES};
        2'd1: rd_data <= data_reg[rd_obj];
        2'd2: rd_data <= link_reg[rd_obj];
        default: rd_data <= '0;
      endcase
  end
  // ---------------------------------------------------------------
  // default pdo table
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pdo_exists <= 1'b0;
      pdo_par_idx <= '0;
      pdo_map_idx <= '0;
      pdo_cob_id <= '0;
      pdo_map1 <= '0;
      pdo_map2 <= '0;
    end
    else
    begin
      pdo_par_idx <= (pdo_tx ? OCM_IDX_TX_PAR : OCM_IDX_RX_PAR) +
                     16'(pdo_num) - 16'h0001;
      pdo_map_idx <= (pdo_tx ? OCM_IDX_TX_MAP : OCM_IDX_RX_MAP) +
                     16'(pdo_num) - 16'h0001;
      pdo_cob_id <= OCM_COB_NONE;
      pdo_map1 <= '0;
      pdo_map2 <= '0;
      pdo_exists <= 1'b1;
      if (!pdo_tx)
        case (pdo_num)
          6'd1: begin pdo_cob_id <= 32'(OCM_COB_RX1 + 11'(node_id));
                pdo_map1 <= 32'h6040_0010; end
          6'd2: begin pdo_cob_id <= 32'(OCM_COB_RX2 + 11'(node_id));
                pdo_map1 <= 32'h6040_0010; pdo_map2 <= 32'h6060_0008; end
          6'd6: begin pdo_map1 <= 32'h6040_0010;
                pdo_map2 <= 32'h6042_0010; end
          6'd7: begin pdo_map1 <= 32'h6040_0010;
                pdo_map2 <= 32'h60FE_0120; end
          6'd8: begin pdo_map1 <= 32'h6040_0010;
                pdo_map2 <= 32'h6060_0008; end
          6'd21: begin pdo_map1 <= 32'h6048_0120;
                 pdo_map2 <= 32'h6048_0210; end
          6'd22: begin pdo_map1 <= 32'h6049_0120;
                 pdo_map2 <= 32'h6049_0210; end
          6'd23: begin pdo_map1 <= 32'h604A_0120;
                 pdo_map2 <= 32'h604A_0210; end
          6'd24: begin pdo_map1 <= 32'h604C_0120;
                 pdo_map2 <= 32'h604C_0220; end
          6'd36: pdo_map1 <= 32'h2000_0010;
          6'd37: pdo_map1 <= 32'h2010_0010;
          6'd38: pdo_map1 <= 32'h2020_0010;
          6'd39: pdo_map1 <= 32'h2030_0010;
          6'd40: pdo_map1 <= 32'h2040_0110;
          6'd41: pdo_map1 <= 32'h2050_0110;
          default: pdo_exists <= 1'b0;
        endcase
      else
        case (pdo_num)
          6'd1: begin pdo_cob_id <= 32'(OCM_COB_TX1 + 11'(node_id));
                pdo_map1 <= 32'h6041_0010; end
          6'd2: begin pdo_cob_id <= 32'(OCM_COB_TX2 + 11'(node_id));
                pdo_map1 <= 32'h6041_0010; pdo_map2 <= 32'h6061_0008; end
          6'd6: begin pdo_map1 <= 32'h6041_0010;
                pdo_map2 <= 32'h6044_0010; end
          6'd7: begin pdo_map1 <= 32'h6041_0010;
                pdo_map2 <= 32'h60FD_0020; end
          6'd21: pdo_map1 <= 32'h6042_0010;
          6'd22: pdo_map1 <= 32'h6043_0010;
          6'd23: begin pdo_map1 <= 32'h6048_0120;
                 pdo_map2 <= 32'h6048_0210; end
          6'd24: begin pdo_map1 <= 32'h6049_0120;
                 pdo_map2 <= 32'h6049_0210; end
          6'd25: begin pdo_map1 <= 32'h604A_0120;
                 pdo_map2 <= 32'h604A_0210; end
          6'd26: begin pdo_map1 <= 32'h604C_0120;
                 pdo_map2 <= 32'h604C_0220; end
          6'd36: pdo_map1 <= 32'h2100_0010;
          6'd37: pdo_map1 <= 32'h2110_0010;
          6'd38: pdo_map1 <= 32'h2120_0010;
          6'd39: pdo_map1 <= 32'h2130_0010;
          6'd40: pdo_map1 <= 32'h2140_0110;
          6'd41: pdo_map1 <= 32'h2150_0110;
          default: pdo_exists <= 1'b0;
        endcase
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_check_bad;
    state_reg == OCM_ST_CHECK && (bad_forbid || bad_dup || bad_pair);
  endsequence
  property p_keep_link;
    @(posedge sys_clk) disable iff (!rst_b)
    s_check_bad |=> link_reg[$past(obj_reg)] == $past(link_reg[obj_reg]);
  endproperty
  a_keep_link: assert property (p_keep_link)
    else $error("rejected write changed link");
  property p_oper_refused;
    @(posedge sys_clk) disable iff (!rst_b)
    busy && go_oper_req |-> !go_oper_ok;
  endproperty
  a_oper_refused: assert property (p_oper_refused)
    else $error("operational accepted while busy");
  property p_stop_first;
    @(posedge sys_clk) disable iff (!rst_b)
    state_reg == OCM_ST_IDLE && reset_node_req && drive_run &&
    mapped_dirty_reg |=> stop_drive && !do_reset;
  endproperty
  a_stop_first: assert property (p_stop_first)
    else $error("reset before stop");
  property p_no_write_oper;
    @(posedge sys_clk) disable iff (!rst_b)
    state_reg == OCM_ST_CHECK && !node_preop |=>
      link_reg[$past(obj_reg)] == $past(link_reg[obj_reg]);
  endproperty
  a_no_write_oper: assert property (p_no_write_oper)
    else $error("write taken outside pre-operational");
  property p_run_block;
    @(posedge sys_clk) disable iff (!rst_b)
    state_reg == OCM_ST_CHECK && drive_run |=>
      link_reg[$past(obj_reg)] == $past(link_reg[obj_reg]);
  endproperty
  a_run_block: assert property (p_run_block)
    else $error("write taken while running");
  property p_entries;
    @(posedge sys_clk) disable iff (!rst_b)
    rd_sub == 2'd0 |=> rd_data == 32'h0000_0002;
  endproperty
  a_entries: assert property (p_entries)
    else $error("entry count wrong");
  property p_rx1_cob;
    @(posedge sys_clk) disable iff (!rst_b)
    !pdo_tx && pdo_num == 6'd1 |=> pdo_cob_id == 32'(11'h200 +
      11'($past(node_id)));
  endproperty
  a_rx1_cob: assert property (p_rx1_cob)
    else $error("rx pdo 1 cob id wrong");
  property p_tx_idx;
    @(posedge sys_clk) disable iff (!rst_b)
    pdo_tx && pdo_num == 6'd7 |=> pdo_par_idx == 16'h1806 &&
      pdo_map_idx == 16'h1A06;
  endproperty
  a_tx_idx: assert property (p_tx_idx)
    else $error("tx pdo index wrong");
endmodule : ocm_mapper

// [ocm_drive_model.sv]
// drive register space seen through the same-cycle fetch port
module ocm_drive_model (
  input wire logic [15:0] drv_addr,
  output logic [15:0] drv_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // every register holds a value made from its own address
  assign drv_data = drv_addr ^ 16'hA55A;
endmodule : ocm_drive_model

// [ocm_mapper_test.sv]
module ocm_mapper_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ocm_pkg::*;
  // -------------------------------------------------------------
  // stimulus and observed signals
  // -------------------------------------------------------------
  logic sys_clk = 0, rst_b = 0, node_preop = 1, drive_run = 0;
  logic wr_valid = 0, go_oper_req = 0, other_req = 0;
  logic reset_node_req = 0, ans_ready = 0, pdo_tx = 0;
  logic [6:0] node_id = 0;
  logic [1:0] wr_obj = 0, rd_obj = 0, rd_sub = 0, ans_code;
  logic [31:0] wr_addr = 0, rd_data, pdo_cob_id, pdo_map1, pdo_map2;
  logic [5:0] pdo_num = 0;
  logic wr_ready, ans_valid, go_oper_ok, stop_drive, do_reset;
  logic pdo_exists;
  logic [15:0] emcy_code, drv_addr, drv_data, pdo_par_idx, pdo_map_idx;
  int n_errors = 0, compares = 0, cyc = 0;
  ocm_mapper dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .node_preop(node_preop), .drive_run(drive_run), .node_id(node_id),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_obj(wr_obj),
    .wr_addr(wr_addr), .go_oper_req(go_oper_req), .other_req(other_req),
    .reset_node_req(reset_node_req), .ans_valid(ans_valid),
    .ans_ready(ans_ready), .ans_code(ans_code), .emcy_code(emcy_code),
    .go_oper_ok(go_oper_ok), .stop_drive(stop_drive),
    .do_reset(do_reset), .rd_obj(rd_obj), .rd_sub(rd_sub),
    .rd_data(rd_data), .drv_addr(drv_addr), .drv_data(drv_data),
    .pdo_tx(pdo_tx), .pdo_num(pdo_num), .pdo_exists(pdo_exists),
    .pdo_par_idx(pdo_par_idx), .pdo_map_idx(pdo_map_idx),
    .pdo_cob_id(pdo_cob_id), .pdo_map1(pdo_map1), .pdo_map2(pdo_map2));
  ocm_drive_model drive (.drv_addr(drv_addr), .drv_data(drv_data));
  // 100 ns clock
  always #50 sys_clk = ~sys_clk;
  // hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      tally_and_finish;
    end
  end
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic tally_and_finish;
    if (n_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic step;
    @(posedge sys_clk);
    #1;
  endtask : step
  // address write held until the block takes it
  task automatic wr(input logic [1:0] o, input logic [31:0] a);
    int n;
    n = 0;
    wr_valid = 1;
    wr_obj = o;
    wr_addr = a;
    #1;
    while (wr_ready !== 1'b1 && n < 50)
    begin
      step;
      n++;
    end
    step;
    wr_valid = 0;
  endtask : wr
  task automatic get(output logic [1:0] c, output logic [15:0] e);
    int n;
    n = 0;
    while (ans_valid !== 1'b1 && n < 50)
    begin
      step;
      n++;
    end
    c = ans_code;
    e = emcy_code;
    ans_ready = 1;
    step;
    ans_ready = 0;
    step;
  endtask : get
  task automatic wa(input logic [1:0] o, input logic [31:0] a,
    input logic [1:0] x);
    logic [1:0] c;
    logic [15:0] e;
    wr(o, a);
    get(c, e);
    chk(32'(c), 32'(x));
  endtask : wa
  task automatic rd(input logic [1:0] o, input logic [1:0] s,
    input logic [31:0] x);
    rd_obj = o;
    rd_sub = s;
    step;
    chk(rd_data, x);
  endtask : rd
  // expected data: both linked registers as the drive holds them
  function automatic logic [31:0] dv(input logic [31:0] a);
    return {a[31:16] ^ 16'hA55A, a[15:0] ^ 16'hA55A};
  endfunction : dv
  function automatic logic [31:0] ec(input int t, input int n);
    if (n > 2)
      return OCM_COB_NONE;
    return 32'((t ? (n == 1 ? OCM_COB_TX1 : OCM_COB_TX2) :
      (n == 1 ? OCM_COB_RX1 : OCM_COB_RX2)) + 11'(node_id));
  endfunction : ec
  // index and subindex of both default entries, zero when unchecked
  function automatic logic [47:0] em(input int t, input int n);
    logic [15:0] b;
    b = t ? 16'h6041 : 16'h6040;
    if (n == 1)
      return {b, 8'h00, 24'h0};
    if (n == 2)
      return {b, 8'h00, t ? 16'h6061 : 16'h6060, 8'h00};
    if (n == 7)
      return {b, 8'h00, t ? 16'h60FD : 16'h60FE, t ? 8'h00 : 8'h01};
    if (n >= 36)
      return {(t ? 16'h2100 : 16'h2000) + 16'((n - 36) * 16),
        n >= 40 ? 8'h01 : 8'h00, 24'h0};
    return 0;
  endfunction : em
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial
  begin
    logic [1:0] c0, c1;
    logic [15:0] e0, e1, r;
    logic [47:0] m;
    logic [31:0] pt [7] = '{32'h0007_0009, 32'h0201_0202, 32'h0202_0201,
      32'h0201_0203, 32'h0202_0202, 32'h0200_FFFF, 32'hFFFF_0200};
    logic [6:0] pok = 7'b1100011;
    logic [15:0] f [5] = '{OCM_FORBID0, OCM_FORBID1, OCM_FORBID2,
      OCM_FORBID3, OCM_FORBID4};
    int s;
    void'($urandom(35792));
    node_id = 7'($urandom_range(127, 1));
    repeat (2) @(posedge sys_clk);
    #1;
    rst_b = 1;
    rd(0, 0, 32'(OCM_NUM_ENTRIES));
    rd(0, 2, 32'hFFFF_FFFF);
    rd(0, 1, 32'h0000_0000);
    wa(1, 32'h0049_0102, OCM_ANS_OK);
    repeat (10) step;
    rd(1, 2, 32'h0049_0102);
    rd(1, 1, dv(32'h0049_0102));
    for (int k = 0; k < 7; k++)
      wa(0, pt[k], pok[k] ? OCM_ANS_OK : OCM_ANS_ERR);
    for (int k = 0; k < 4; k++)
    begin
      r = 16'h0300 + 16'($urandom_range(3000));
      wa(2, {r, r + 16'h0001}, OCM_ANS_OK);
      wa(2, {r + 16'h0001, r}, OCM_ANS_ERR);
    end
    rd(2, 2, {r, r + 16'h0001});
    wa(3, 32'h0049_0300, OCM_ANS_ERR);
    rd(3, 2, 32'hFFFF_FFFF);
    // answers pile up in the queue while the master stalls
    for (int k = 0; k < 8; k++)
    begin
      wr(1, k < 5 ? {f[k], 16'h0400} : {16'h0400, f[k - 5]});
      step;
    end
    for (int k = 0; k < 8; k++)
    begin
      get(c0, e0);
      chk(32'(c0), 32'(OCM_ANS_ERR));
    end
    rd(1, 2, 32'h0049_0102);
    node_preop = 0;
    wa(3, 32'h1000_2000, OCM_ANS_ERR);
    node_preop = 1;
    drive_run = 1;
    wa(3, 32'h1000_2000, OCM_ANS_ERR);
    drive_run = 0;
    for (int k = 0; k < 2; k++)
    begin
      wr(3, k ? 32'h3000_4000 : 32'h1000_2000);
      go_oper_req = (k == 0);
      other_req = (k == 1);
      #1;
      chk(32'(go_oper_ok), 0);
      step;
      go_oper_req = 0;
      other_req = 0;
      get(c0, e0);
      get(c1, e1);
      chk(32'((c0 === 2'h2 && e0 === OCM_EMCY_CODE) ||
        (c1 === 2'h2 && e1 === OCM_EMCY_CODE)), 1);
    end
    go_oper_req = 1;
    #1;
    chk(32'(go_oper_ok), 1);
    step;
    go_oper_req = 0;
    drive_run = 1;
    reset_node_req = 1;
    step;
    reset_node_req = 0;
    s = 0;
    for (int k = 0; k < 50 && do_reset !== 1'b1; k++)
    begin
      if (stop_drive === 1'b1)
      begin
        s = 1;
        drive_run = 0;
      end
      step;
    end
    chk(32'(do_reset), 1);
    chk(32'(s), 1);
    repeat (3) step;
    rd(1, 2, 32'hFFFF_FFFF);
    for (int t = 0; t < 2; t++)
    begin
      s = 0;
      for (int n = 1; n < 42; n++)
      begin
        pdo_tx = t[0];
        pdo_num = 6'(n);
        step;
        m = em(t, n);
        if (pdo_exists === 1'b1)
        begin
          s++;
          chk(pdo_par_idx, (t ? OCM_IDX_TX_PAR : OCM_IDX_RX_PAR)
            + 16'(n - 1));
          chk(pdo_map_idx, (t ? OCM_IDX_TX_MAP : OCM_IDX_RX_MAP)
            + 16'(n - 1));
          chk(pdo_cob_id, ec(t, n));
          if (m[47:24] != 0)
            chk(pdo_map1[31:8], m[47:24]);
          if (m[23:0] != 0)
            chk(pdo_map2[31:8], m[23:0]);
        end
      end
      chk(s, t ? OCM_TX_COUNT : OCM_RX_COUNT);
    end
    tally_and_finish;
  end
endmodule : ocm_mapper_test
